// file: hw/cstc_top.sv
// CAN interface 1 sync/time identifier configuration and frame gating
//
// Contract
// - Id words: 11-bit id, 28..11 zero
// - Bit 30 set enables generating the message
// - Received time applied only if bit 30
// - Master Off/On: transmit time iff bit 31
// - Default: transmit time only as lowest node
// - Eight selectable rates, default 250 kbit/s
// - Node number 1..127, unique on bus
// - Further identifiers derived from node number
// - On: operational master; Off: wait for start
`timescale 1ns/10ps
`default_nettype none

module cstc_top
(
    // Clock, reset, enable
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Periodic triggers from the protocol engine
    input  wire logic        sync_tick,
    input  wire logic        time_tick,
    // Received frames from the controller
    input  wire logic        rx_valid,
    input  wire logic [10:0] rx_id,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_start_remote,
    // Frame request to the controller
    output logic             tx_req,
    output logic      [10:0] tx_id,
    input  wire logic        tx_ack,
    // Derived state
    output logic      [15:0] bit_cycles,
    output logic             operational,
    output logic             time_master,
    output logic      [10:0] emcy_id,
    output logic      [10:0] hb_id
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] sync_id_r;          // Sync identifier word
    logic [31:0] time_message_identifier_r; // Time identifier word
    logic [1:0]  mode_r;             // Master setting
    logic [2:0]  rate_r;             // Rate code
    logic [6:0]  node_r;             // Node number
    logic [31:0] rx_time_r;          // Last applied time
    logic [6:0]  arb_low_r;          // Lowest competing node seen
    logic        node_err_r;         // Last node write was out of range
    cstc_pkg::cstc_st_t st_r;        // Sender state
    logic        pend_sync_r;        // Sync frame waiting
    logic        pend_time_r;        // Time frame waiting

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire acc     = psel && penable && ce;
    wire wr      = acc && pwrite;
    wire hit_s   = paddr == cstc_pkg::cstc_off_sync_id;
    wire hit_t   = paddr == cstc_pkg::cstc_off_time_id;
    wire hit_c   = paddr == cstc_pkg::cstc_off_ctrl;
    wire hit_st  = paddr == cstc_pkg::cstc_off_status;
    wire hit_rx  = paddr == cstc_pkg::cstc_off_rx_time;
    wire hit_ar  = paddr == cstc_pkg::cstc_off_arb;
    wire hit_any = hit_s | hit_t | hit_c | hit_st | hit_rx | hit_ar;
    // Writes to read-only words are refused like unmapped ones
    wire bad     = !hit_any || (pwrite && (hit_st || hit_rx || hit_ar));

    // Fixed-zero field is forced on write; software cannot set it
    wire [31:0] wid = pwdata & cstc_pkg::cstc_id_keep_mask;
    wire [6:0]  wnode = pwdata[cstc_pkg::cstc_ctrl_node_lsb +: 7];
    wire        node_ok = wnode >= cstc_pkg::cstc_node_min;

    // ------------------------------------------------------------
    // Derived decisions
    // ------------------------------------------------------------
    wire gen_sync  = sync_id_r[cstc_pkg::cstc_bit_gen];
    wire apply_ok  = time_message_identifier_r[cstc_pkg::cstc_bit_gen];
    wire xmit_bit  = time_message_identifier_r[cstc_pkg::cstc_bit_xmit];
    wire is_dflt   = mode_r == cstc_pkg::cstc_mst_dflt;
    // Default master wins only while no lower node number is heard
    wire won       = node_r < arb_low_r;
    wire xmit_time = xmit_bit && (!is_dflt || won);
    wire [10:0] sid = sync_id_r[cstc_pkg::cstc_id_msb:0];
    wire [10:0] tid = time_message_identifier_r[cstc_pkg::cstc_id_msb:0];
    wire rx_time   = rx_valid && rx_id == tid;
    // A foreign node sending on its own heartbeat identifier reveals its number
    wire [6:0] rx_node = rx_id[6:0];
    wire rx_peer   = rx_valid && rx_id[10:7] == cstc_pkg::cstc_base_hb[10:7]
                     && rx_node != node_r;

    wire [31:0] status_w = {25'h0000000, time_master, operational, won,
                            node_err_r, gen_sync, apply_ok, xmit_time};

    // Read mux
    wire [31:0] rd = hit_s  ? sync_id_r :
                     hit_t  ? time_message_identifier_r :
                     hit_c  ? {16'h0000, 1'b0, node_r, 1'b0, rate_r, 2'h0, mode_r} :
                     hit_st ? status_w :
                     hit_rx ? rx_time_r :
                     hit_ar ? {25'h0000000, arb_low_r} : 32'h00000000;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Config words; a write to the same word as an event does not clash
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync_id_r <= cstc_pkg::cstc_sync_rst;
            time_message_identifier_r <= cstc_pkg::cstc_time_rst;
            mode_r <= cstc_pkg::cstc_mst_dflt;
            rate_r <= cstc_pkg::cstc_rate_250;
            node_r <= cstc_pkg::cstc_node_rst;
            node_err_r <= 1'b0;
        end
        else if (wr && !bad)
        begin
            if (hit_s)
                sync_id_r <= wid;
            if (hit_t)
                time_message_identifier_r <= wid;
            if (hit_c)
            begin
                mode_r <= pwdata[cstc_pkg::cstc_ctrl_mode_lsb +: 2];
                rate_r <= pwdata[cstc_pkg::cstc_ctrl_rate_lsb +: 3];
                // Zero is not a legal node number: keep the old one
                if (node_ok)
                    node_r <= wnode;
                node_err_r <= !node_ok;
            end
        end
    end

    // Received time and arbitration tracking
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rx_time_r <= 32'h00000000;
            arb_low_r <= cstc_pkg::cstc_node_none;
        end
        else if (ce)
        begin
            if (rx_time && apply_ok)
                rx_time_r <= rx_data;
            if (rx_peer && rx_node < arb_low_r)
                arb_low_r <= rx_node;
        end
    end

    // ------------------------------------------------------------
    // Operational state
    // ------------------------------------------------------------
    // On: self-start; Off: wait for remote start; Default: self-start, master only while won
    always_ff @(posedge clock)
    begin
        if (rst)
            operational <= 1'b0;
        else if (ce)
        begin
            if (mode_r != cstc_pkg::cstc_mst_off || rx_start_remote)
                operational <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    // Requests latch; a tick arriving on the send edge is kept
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pend_sync_r <= 1'b0;
            pend_time_r <= 1'b0;
            st_r <= cstc_pkg::cstc_st_idle;
            tx_req <= 1'b0;
            tx_id <= 11'h000;
        end
        else if (ce)
        begin
            // Pending flags drop when the enable bit is cleared
            pend_sync_r <= (sync_tick || (pend_sync_r &&
                           !(st_r == cstc_pkg::cstc_st_idle && !pend_time_r)))
                           && gen_sync;
            pend_time_r <= (time_tick || (pend_time_r &&
                           st_r != cstc_pkg::cstc_st_idle)) && xmit_time;
            case (st_r)
                cstc_pkg::cstc_st_idle:
                begin
                    if (operational && pend_time_r && xmit_time)
                    begin
                        tx_id <= tid;
                        tx_req <= 1'b1;
                        st_r <= cstc_pkg::cstc_st_req;
                    end
                    else if (operational && pend_sync_r && gen_sync)
                    begin
                        tx_id <= sid;
                        tx_req <= 1'b1;
                        st_r <= cstc_pkg::cstc_st_req;
                    end
                end
                cstc_pkg::cstc_st_req:
                begin
                    if (tx_ack)
                    begin
                        tx_req <= 1'b0;
                        st_r <= cstc_pkg::cstc_st_wait;
                    end
                end
                cstc_pkg::cstc_st_wait:
                    st_r <= cstc_pkg::cstc_st_idle;
                default:
                    st_r <= cstc_pkg::cstc_st_idle;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs and bus answer
    // ------------------------------------------------------------
    // Node-derived identifiers and single-cycle APB answer
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            emcy_id <= 11'h000;
            hb_id <= 11'h000;
            time_master <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            emcy_id <= cstc_pkg::cstc_base_emcy + {4'h0, node_r};
            hb_id <= cstc_pkg::cstc_base_hb + {4'h0, node_r};
            time_master <= xmit_time;
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad;
            prdata <= (psel && !penable && !pwrite) ? rd : 32'h00000000;
        end
    end

    // Rate lookup
    cstc_rate_sel u_rate
    (
        .clock      (clock),
        .rst        (rst),
        .ce         (ce),
        .rate_code  (rate_r),
        .bit_cycles (bit_cycles)
    );

endmodule

`default_nettype wire

// file: hw/cstc_pkg.sv
// Package with register map, field layout and constants of the CAN sync/time config block
package cstc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets (APB, one 32-bit word each)
    // ------------------------------------------------------------
    localparam logic [7:0] cstc_off_sync_id   = 8'h00; // Sync identifier word
    localparam logic [7:0] cstc_off_time_id   = 8'h04; // Time identifier word
    localparam logic [7:0] cstc_off_ctrl      = 8'h08; // Master setting, rate, node number
    localparam logic [7:0] cstc_off_status    = 8'h0C; // Derived state, read only
    localparam logic [7:0] cstc_off_rx_time   = 8'h10; // Last applied received time
    localparam logic [7:0] cstc_off_arb       = 8'h14; // Lowest competing node number seen

    // ------------------------------------------------------------
    // Identifier word layout
    // ------------------------------------------------------------
    localparam int cstc_bit_xmit  = 31; // Transmit time enable
    localparam int cstc_bit_gen   = 30; // Generate / apply bit
    localparam int cstc_id_msb    = 10; // Top of 11-bit identifier
    localparam int cstc_zero_msb  = 28; // Fixed-zero field top
    localparam int cstc_zero_lsb  = 11; // Fixed-zero field bottom
    localparam logic [31:0] cstc_id_keep_mask = 32'hE00007FF; // Clears bits 28..11

    // Reset values of the identifier words
    localparam logic [31:0] cstc_sync_rst = 32'h00000080;
    localparam logic [31:0] cstc_time_rst = 32'h00000100;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    localparam int cstc_ctrl_mode_lsb = 0;  // Two bits master setting
    localparam int cstc_ctrl_rate_lsb = 4;  // Three bits rate select
    localparam int cstc_ctrl_node_lsb = 8;  // Seven bits node number

    // Master setting encoding
    typedef enum logic [1:0]
    {
        cstc_mst_off  = 2'h0,
        cstc_mst_dflt = 2'h1,
        cstc_mst_on   = 2'h2
    } cstc_mst_t;

    // Rate select encoding: 20,50,100,125,250,500,800,1000 kbit/s
    localparam logic [2:0] cstc_rate_250 = 3'h4; // Default rate
    localparam logic [6:0] cstc_node_min = 7'h01; // Lowest legal node number
    localparam logic [6:0] cstc_node_rst = 7'h7F; // Reset node number
    localparam logic [6:0] cstc_node_none = 7'h7F; // No competitor seen yet

    // Clock and bit timing: cycles per bit at 250 MHz
    localparam int cstc_clk_mhz = 250;
    localparam logic [15:0] cstc_bt_20   = 16'(cstc_clk_mhz * 1000 / 20);
    localparam logic [15:0] cstc_bt_50   = 16'(cstc_clk_mhz * 1000 / 50);
    localparam logic [15:0] cstc_bt_100  = 16'(cstc_clk_mhz * 1000 / 100);
    localparam logic [15:0] cstc_bt_125  = 16'(cstc_clk_mhz * 1000 / 125);
    localparam logic [15:0] cstc_bt_250  = 16'(cstc_clk_mhz * 1000 / 250);
    localparam logic [15:0] cstc_bt_500  = 16'(cstc_clk_mhz * 1000 / 500);
    localparam logic [15:0] cstc_bt_800  = 16'(cstc_clk_mhz * 1000 / 800);
    localparam logic [15:0] cstc_bt_1000 = 16'(cstc_clk_mhz * 1000 / 1000);

    // Identifier bases for node-derived objects (emergency, transmit and heartbeat bases)
    localparam logic [10:0] cstc_base_emcy = 11'h080;
    localparam logic [10:0] cstc_base_tx   = 11'h180;
    localparam logic [10:0] cstc_base_hb   = 11'h700;

    // Frame sender states
    typedef enum logic [1:0]
    {
        cstc_st_idle = 2'h0,
        cstc_st_req  = 2'h1,
        cstc_st_wait = 2'h3
    } cstc_st_t;

endpackage

// file: hw/cstc_rate_sel.sv
// Bit-rate selector: maps the rate code to cycles per bit
`timescale 1ns/10ps
`default_nettype none

module cstc_rate_sel
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // Rate code
    input  wire logic [2:0]  rate_code,
    // Cycles per bit, registered
    output logic      [15:0] bit_cycles
);

    // ------------------------------------------------------------
    // Table lookup
    // ------------------------------------------------------------
    logic [15:0] bit_cycles_nxt; // Looked-up period

    // Each code picks one of the eight supported rates
    always_comb
    begin
        case (rate_code)
            3'h0:    bit_cycles_nxt = cstc_pkg::cstc_bt_20;
            3'h1:    bit_cycles_nxt = cstc_pkg::cstc_bt_50;
            3'h2:    bit_cycles_nxt = cstc_pkg::cstc_bt_100;
            3'h3:    bit_cycles_nxt = cstc_pkg::cstc_bt_125;
            3'h4:    bit_cycles_nxt = cstc_pkg::cstc_bt_250;
            3'h5:    bit_cycles_nxt = cstc_pkg::cstc_bt_500;
            3'h6:    bit_cycles_nxt = cstc_pkg::cstc_bt_800;
            default: bit_cycles_nxt = cstc_pkg::cstc_bt_1000;
        endcase
    end

    // Registered so the period feeds the top output from a flop
    always_ff @(posedge clock)
    begin
        if (rst)
            bit_cycles <= cstc_pkg::cstc_bt_250;
        else if (ce)
            bit_cycles <= bit_cycles_nxt;
    end

endmodule

`default_nettype wire

// file: sim/cstc_top_props.sv
// Assertion checker for the sync/time identifier block, bound to its top
`timescale 1ns/10ps
`default_nettype none

module cstc_top_props
(
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        ce,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Frame request and derived state
    input wire logic        tx_req,
    input wire logic [10:0] tx_id,
    input wire logic        tx_ack,
    input wire logic [15:0] bit_cycles,
    input wire logic        operational,
    input wire logic [10:0] emcy_id,
    input wire logic [10:0] hb_id
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Shadows of the identifier words and the master setting
    logic [31:0] sync_r;
    logic [31:0] time_r;
    logic [1:0]  mode_r;
    wire         wr_done = psel && penable && pready && pwrite && ce;
    wire         rd_id   = psel && penable && pready && !pwrite && paddr[7:3] == 5'h00;

    // Follow accepted writes; the mask mirrors the fixed-zero field
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync_r <= cstc_pkg::cstc_sync_rst;
            time_r <= cstc_pkg::cstc_time_rst;
            mode_r <= cstc_pkg::cstc_mst_dflt;
        end
        else if (wr_done && paddr == cstc_pkg::cstc_off_sync_id)
            sync_r <= pwdata & cstc_pkg::cstc_id_keep_mask;
        else if (wr_done && paddr == cstc_pkg::cstc_off_time_id)
            time_r <= pwdata & cstc_pkg::cstc_id_keep_mask;
        else if (wr_done && paddr == cstc_pkg::cstc_off_ctrl)
            mode_r <= pwdata[1:0];
    end

    // Bus phases
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_ack_slot: assert property (s_setup |=> s_access)
        else $error("access phase not answered");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_read_back: assert property (rd_id |-> prdata == (paddr[2] ? time_r : sync_r))
        else $error("identifier word read back wrong");
    a_tx_enabled: assert property ($rose(tx_req) |->
        (tx_id == sync_r[10:0] && sync_r[30]) || (tx_id == time_r[10:0] && time_r[31]))
        else $error("frame sent without its enable bit");
    a_tx_hold: assert property (tx_req && !tx_ack |=> tx_req && $stable(tx_id))
        else $error("frame request dropped or changed");
    a_req_release: assert property (tx_req && tx_ack |=> !tx_req)
        else $error("request kept after acknowledge");
    a_rate_set: assert property (bit_cycles inside {16'h30D4, 16'h1388, 16'h09C4,
        16'h07D0, 16'h03E8, 16'h01F4, 16'h0138, 16'h00FA})
        else $error("bit time outside the rate table");
    a_node_ids: assert property (!$past(rst) && !$past(rst, 2) |-> hb_id - emcy_id == 11'h680)
        else $error("derived identifiers disagree");
    a_oper_on: assert property (mode_r == 2'h2 |-> ##[0:8] operational)
        else $error("master setting on but not operational");
endmodule

bind cstc_top cstc_top_props cstc_top_props_inst (.clock, .rst, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .tx_req, .tx_id, .tx_ack, .bit_cycles, .operational,
    .emcy_id, .hb_id);
`default_nettype wire

// file: sim/cstc_ctl_model.sv
// Frame controller model: takes frame requests and acknowledges them
`timescale 1ns/10ps
`default_nettype none

module cstc_ctl_model
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Frame request from the block
    input  wire logic        tx_req,
    input  wire logic [10:0] tx_id,
    output logic             tx_ack,
    // Bench control and observation
    input  wire logic [3:0]  delay,
    output logic      [7:0]  tx_count,
    output logic      [10:0] last_id
);
    logic [3:0] wait_r; // Cycles the current request has waited

    // Acknowledge after a set wait, as a one-cycle pulse
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tx_ack   <= 1'b0;
            wait_r   <= 4'h0;
            tx_count <= 8'h00;
            last_id  <= 11'h000;
        end
        else if (tx_ack || !tx_req)
        begin
            // Pulse over; a slow bus shows up as a large delay
            tx_ack <= 1'b0;
            wait_r <= 4'h0;
        end
        else if (wait_r >= delay)
        begin
            tx_ack   <= 1'b1;
            tx_count <= tx_count + 8'h01;
            last_id  <= tx_id;
        end
        else
            wait_r <= wait_r + 4'h1;
    end
endmodule
`default_nettype wire

// file: sim/cstc_top_tb.sv
// Self-checking bench for the sync/time identifier block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t %h %h", $time, g, e); end end

module cstc_top_tb;
    // Bench signals
    logic        clock = 1'b0;
    logic        rst, ce, psel, penable, pwrite, pready, pslverr, sync_tick, time_tick;
    logic        rx_valid, rx_start_remote, tx_req, tx_ack, operational, time_master, rd_e;
    logic [7:0]  paddr, tx_count;
    logic [31:0] pwdata, prdata, rx_data, rd_q, rx_exp;
    logic [10:0] rx_id, tx_id, emcy_id, hb_id, last_id;
    logic [15:0] bit_cycles;
    logic [3:0]  delay;
    int          failures = 0;
    int          cmp_count = 0;
    logic [15:0] bt [8] = '{16'h30D4, 16'h1388, 16'h09C4, 16'h07D0,
                            16'h03E8, 16'h01F4, 16'h0138, 16'h00FA};
    logic [1:0]  mds [3] = '{2'h0, 2'h2, 2'h1};

    // 250 MHz clock
    always #2 clock = ~clock;

    cstc_top cstc_top_inst (.clock, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sync_tick, .time_tick, .rx_valid, .rx_id, .rx_data,
        .rx_start_remote, .tx_req, .tx_id, .tx_ack, .bit_cycles, .operational, .time_master,
        .emcy_id, .hb_id);
    cstc_ctl_model cstc_ctl_model_inst (.clock, .rst, .tx_req, .tx_id, .tx_ack, .delay,
        .tx_count, .last_id);

    // One bus transfer, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Access phase lasts until ready is seen at a rising edge; the watchdog ends a hang
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd_q = prdata;
        rd_e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd_q, e)
    endtask

    // Trigger one frame and see whether the controller got it
    task automatic try_tx(input logic tm, input logic ex, input logic [10:0] id);
        logic [7:0] base;
        base = tx_count;
        time_tick <= tm;
        sync_tick <= !tm;
        @(posedge clock);
        time_tick <= 1'b0;
        sync_tick <= 1'b0;
        repeat (24) @(posedge clock);
        `CHK(tx_count != base, ex)
        if (ex) `CHK(last_id, id)
    endtask

    // Received frame; idle lines stop showing the old frame
    task automatic send(input logic [10:0] id, input logic [31:0] d);
        rx_id    <= id;
        rx_data  <= d;
        rx_valid <= 1'b1;
        @(posedge clock);
        rx_id    <= ~id;
        rx_data  <= ~d;
        rx_valid <= 1'b0;
        @(posedge clock);
    endtask

    task automatic close_out;
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        close_out;
    end

    // Main sequence
    initial
    begin
        {rst, ce, psel, penable, pwrite, sync_tick, time_tick} = 7'h60;
        {rx_valid, rx_start_remote, paddr, rx_id, delay} = 25'h0000001;
        {pwdata, rx_data, rx_exp} = 96'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        `CHK(bit_cycles, 16'h03E8)
        rd(cstc_pkg::cstc_off_sync_id, 32'h00000080);
        rd(cstc_pkg::cstc_off_time_id, 32'h00000100);
        rd(cstc_pkg::cstc_off_arb, 32'h0000007F);
        apb(1'b1, cstc_pkg::cstc_off_sync_id, 32'hFFFFFFFF);
        rd(cstc_pkg::cstc_off_sync_id, 32'hE00007FF);
        apb(1'b1, 8'h18, 32'h00000000);
        `CHK(rd_e, 1'b1)
        apb(1'b1, cstc_pkg::cstc_off_status, 32'h00000000);
        `CHK(rd_e, 1'b1)
        // Every rate code, master on, node follows the code
        for (int r = 0; r < 8; r++)
        begin
            apb(1'b1, cstc_pkg::cstc_off_ctrl, {17'h0, 7'(r + 1), 1'b0, 3'(r), 4'h2});
            repeat (3) @(posedge clock);
            `CHK(bit_cycles, bt[r])
            `CHK(emcy_id, 11'(11'h080 + r + 1))
            `CHK(hb_id, 11'(11'h700 + r + 1))
            `CHK(operational, 1'b1)
        end
        apb(1'b1, cstc_pkg::cstc_off_ctrl, 32'h00000042);
        repeat (3) @(posedge clock);
        `CHK(emcy_id, 11'h088)
        apb(1'b0, cstc_pkg::cstc_off_status, 32'h00000000);
        `CHK(rd_q[3], 1'b1)
        apb(1'b1, cstc_pkg::cstc_off_ctrl, 32'h00000542);
        apb(1'b1, cstc_pkg::cstc_off_sync_id, 32'h40000080);
        try_tx(1'b0, 1'b1, 11'h080);
        apb(1'b1, cstc_pkg::cstc_off_sync_id, 32'h00000080);
        try_tx(1'b0, 1'b0, 11'h080);
        // Master settings Off, On, Default against all bit 31/30 pairs
        for (int m = 0; m < 3; m++)
        begin
            delay <= (m == 1) ? 4'h9 : 4'h1;
            apb(1'b1, cstc_pkg::cstc_off_ctrl, {24'h000005, 6'h10, mds[m]});
            if (m == 0)
            begin
                rx_start_remote <= 1'b1;
                @(posedge clock);
                rx_start_remote <= 1'b0;
                repeat (3) @(posedge clock);
                `CHK(operational, 1'b1)
            end
            for (int b = 3; b >= 0; b--)
            begin
                apb(1'b1, cstc_pkg::cstc_off_time_id, {2'(b), 19'h0, 11'h100});
                try_tx(1'b1, b[1], 11'h100);
                `CHK(time_master, b[1])
                send(11'h100, {4'(b), 4'(m), 24'hA5C300});
                if (b[0]) rx_exp = {4'(b), 4'(m), 24'hA5C300};
                rd(cstc_pkg::cstc_off_rx_time, rx_exp);
            end
        end
        // A peer with a lower node number takes the master role
        apb(1'b1, cstc_pkg::cstc_off_time_id, 32'h80000100);
        send(11'h702, 32'h00000000);
        rd(cstc_pkg::cstc_off_arb, 32'h00000002);
        try_tx(1'b1, 1'b0, 11'h100);
        `CHK(time_master, 1'b0)
        close_out;
    end
endmodule
`default_nettype wire
